//--- hdl/lnbc_pkg.sv
// Constants and types shared by the LNB controller register interface
package lnbc_pkg;

   localparam int         BYTE_BITS     = 8;
   localparam logic [4:0] ADDR_FIXED    = 5'h02;
   localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
   localparam logic [7:0] REG_RESET     = 8'h00;

   localparam logic [2:0] SEL_STATUS    = 3'h0;
   localparam logic [2:0] SEL_TONE      = 3'h1;
   localparam logic [2:0] SEL_COMMAND   = 3'h2;
   localparam logic [2:0] SEL_CONTROL   = 3'h3;

   localparam int         SEL_MSB       = 7;
   localparam int         SEL_LSB       = 5;

   localparam int         TONE_EN_BIT   = 4;
   localparam int         MOD_SEL_BIT   = 3;
   localparam int         TONE_THR_BIT  = 2;

   localparam int         CUR_MODE_BIT  = 4;
   localparam int         VPIN_EN_BIT   = 3;
   localparam int         ILIM_HI_BIT   = 1;
   localparam int         ILIM_LO_BIT   = 0;

   localparam int         OUT_EN_BIT    = 4;
   localparam int         HI_RANGE_BIT  = 1;
   localparam int         LO_RANGE_BIT  = 0;

   typedef struct packed {
      logic overtemp_flag;
      logic open_cable_flag;
      logic voltage_range_fault;
      logic overload_flag;
      logic back_current_flag;
   } lnbc_status_t;

   typedef struct packed {
      logic tone_enable;
      logic modulation_select;
      logic tone_threshold_sel;
   } lnbc_tone_t;

   typedef struct packed {
      logic current_mode_sel;
      logic voltage_pin_enable;
      logic ilimit_sel_high;
      logic ilimit_sel_low;
   } lnbc_cmd_t;

   typedef struct packed {
      logic output_enable;
      logic high_range_sel;
      logic low_range_sel;
   } lnbc_ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WRITE,
      ST_WRITE_ACK,
      ST_READ,
      ST_READ_ACK,
      ST_IGNORE
   } lnbc_state_t;

   typedef struct packed {
      logic         scl_m;
      logic         scl_s;
      logic         scl_d;
      logic         sda_m;
      logic         sda_s;
      logic         sda_d;
      logic         pg_m;
      logic         pg_s;
      logic [1:0]   asel_m;
      logic [1:0]   asel_s;
      lnbc_status_t stat_m;
      lnbc_status_t stat_s;
      lnbc_state_t  state;
      logic [3:0]   cnt;
      logic [7:0]   shreg;
      logic [7:0]   tx;
      logic         rw;
      logic         more;
      logic [1:0]   rd_ptr;
      logic         drive;
      lnbc_tone_t   tone;
      lnbc_cmd_t    cmd;
      lnbc_ctrl_t   ctrl;
   } lnbc_core_t;

endpackage

//--- hdl/lnbc_i2c_regs.sv
// Two-wire slave and system registers of the LNB supply controller
// Notes on behaviour
// R1: SDA is only sampled on SCL rise and only changed after SCL falls.
// R2: SDA falling while SCL high is a start; it begins a transfer.
// R3: SDA rising while SCL high is a stop; it ends the transfer.
// R4: Master sends stop before every new start; no repeated start.
// R5: Bytes are eight bits, MSB first, each followed by one acknowledge bit.
// R6: Receiver holds SDA low through the ninth clock to acknowledge.
// R7: No acknowledge is driven while power-good is low.
// R8: Address is 00010, two select pins, then direction bit, 1 read.
// R9: Write is start, address, ack, data, ack, stop; both bytes acked.
// R10: Top three data bits pick register: 000 status to 011 control.
// R11: Only tone, command, control take writes; don't-care bits ignored.
// R12: Reset clears all four registers to zero.
// R13: Status low bits: overtemp, open cable, range fault, overload, back current.
// R14: Overload flag shows the overload input live.
// R15: Back-current and voltage-range flags show their inputs live.
// R16: Open-cable flag shows the open-cable input live.
// R17: Over-temperature flag shows the over-temperature input live.
// R18: Tone enable and modulation select pick the tone source.
// R19: Tone threshold bit selects receive or transmit decoder threshold.
// R20: Two current-limit bits pick one of four output current limits.
// R21: Current-mode bit 0 is dynamic limiting, 1 is static.
// R22: Voltage-pin-enable 0 enables the range pin, 1 disables it.
// R23: Read sends register bytes MSB first; master ack asks for more.
// R24: While power-good is low, bus ignored and registers held at zero.
// R25: Address pins give four addresses 0001000 to 0001011.
// R26: Undefined select codes change nothing but the byte is still acked.
// R27: Control holds output enable bit 4, range selects bits 1 and 0.
`timescale 1ns/100ps
`default_nettype none

module lnbc_i2c_regs
(
   input  wire logic                  i_clock,
   input  wire logic                  i_resetn,
   input  wire logic                  i_scl,
   input  wire logic                  i_sda,
   output logic                       o_sda,
   output logic                       o_sda_oe_n,
   input  wire logic                  i_addr_sel_hi,
   input  wire logic                  i_addr_sel_lo,
   input  wire logic                  i_power_good,
   input  wire lnbc_pkg::lnbc_status_t i_status,
   output lnbc_pkg::lnbc_tone_t       o_tone,
   output lnbc_pkg::lnbc_cmd_t        o_cmd,
   output lnbc_pkg::lnbc_ctrl_t       o_ctrl
);

   lnbc_pkg::lnbc_core_t r;
   lnbc_pkg::lnbc_core_t r_nxt;

   // Byte that the master would read back for a given register pointer
   function automatic logic [7:0] read_byte(input lnbc_pkg::lnbc_core_t s,
                                            input logic [1:0]           ptr);
      logic [7:0] b;
      b = lnbc_pkg::REG_RESET;
      case (ptr)
         2'h0:
         begin
            b[lnbc_pkg::SEL_MSB:lnbc_pkg::SEL_LSB] = lnbc_pkg::SEL_STATUS;
            b[4:0] = s.stat_s;                                      // R13
         end
         2'h1:
         begin
            b[lnbc_pkg::SEL_MSB:lnbc_pkg::SEL_LSB] = lnbc_pkg::SEL_TONE;
            b[lnbc_pkg::TONE_EN_BIT]  = s.tone.tone_enable;
            b[lnbc_pkg::MOD_SEL_BIT]  = s.tone.modulation_select;
            b[lnbc_pkg::TONE_THR_BIT] = s.tone.tone_threshold_sel;
         end
         2'h2:
         begin
            b[lnbc_pkg::SEL_MSB:lnbc_pkg::SEL_LSB] = lnbc_pkg::SEL_COMMAND;
            b[lnbc_pkg::CUR_MODE_BIT] = s.cmd.current_mode_sel;
            b[lnbc_pkg::VPIN_EN_BIT]  = s.cmd.voltage_pin_enable;
            b[lnbc_pkg::ILIM_HI_BIT]  = s.cmd.ilimit_sel_high;
            b[lnbc_pkg::ILIM_LO_BIT]  = s.cmd.ilimit_sel_low;
         end
         default:
         begin
            b[lnbc_pkg::SEL_MSB:lnbc_pkg::SEL_LSB] = lnbc_pkg::SEL_CONTROL;
            b[lnbc_pkg::OUT_EN_BIT]   = s.ctrl.output_enable;
            b[lnbc_pkg::HI_RANGE_BIT] = s.ctrl.high_range_sel;
            b[lnbc_pkg::LO_RANGE_BIT] = s.ctrl.low_range_sel;
         end
      endcase
      return b;
   endfunction

   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic       addr_match;
   logic [2:0] bit_idx;
   logic [7:0] next_tx;
   logic [7:0] first_tx;

   always_comb
   begin
      r_nxt = r;
      // Synchronisers; first stages feed only the second stages
      r_nxt.scl_m  = i_scl;
      r_nxt.scl_s  = r.scl_m;
      r_nxt.scl_d  = r.scl_s;
      r_nxt.sda_m  = i_sda;
      r_nxt.sda_s  = r.sda_m;
      r_nxt.sda_d  = r.sda_s;
      r_nxt.pg_m   = i_power_good;
      r_nxt.pg_s   = r.pg_m;
      r_nxt.asel_m = {i_addr_sel_hi, i_addr_sel_lo};
      r_nxt.asel_s = r.asel_m;
      r_nxt.stat_m = i_status;
      r_nxt.stat_s = r.stat_m;                                      // R14 R15 R16 R17

      scl_rise  = r.scl_s & ~r.scl_d;
      scl_fall  = ~r.scl_s & r.scl_d;
      bus_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;           // R2
      bus_stop  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;           // R3
      // Select pins are synced; a change applies from the next address byte
      addr_match = (r.shreg[7:3] == lnbc_pkg::ADDR_FIXED) &&
                   (r.shreg[2:1] == r.asel_s);                      // R8 R25
      // Next read bit; cnt holds the rises already seen in this byte
      bit_idx = 3'(4'h7 - r.cnt);
      next_tx = read_byte(r, 2'(r.rd_ptr + 2'h1));
      first_tx = read_byte(r, 2'h0);

      case (r.state)
         lnbc_pkg::ST_IDLE:
         begin
            r_nxt.drive = 1'b0;
         end
         lnbc_pkg::ST_ADDR:
         begin
            if (scl_rise && r.cnt != lnbc_pkg::CNT_BYTE_DONE)
            begin
               r_nxt.shreg = {r.shreg[6:0], r.sda_s};               // R1 R5
               r_nxt.cnt   = 4'(r.cnt + 4'h1);
            end
            else if (scl_fall && r.cnt == lnbc_pkg::CNT_BYTE_DONE)
            begin
               r_nxt.rw = r.shreg[0];
               if (addr_match)
               begin
                  r_nxt.drive = 1'b1;                               // R6 R7
                  r_nxt.state = lnbc_pkg::ST_ADDR_ACK;
               end
               else
               begin
                  // Another slave is addressed; stay off the line until stop
                  r_nxt.state = lnbc_pkg::ST_IGNORE;
               end
            end
         end
         lnbc_pkg::ST_ADDR_ACK:
         begin
            if (scl_fall)
            begin
               r_nxt.cnt = 4'h0;
               if (r.rw)
               begin
                  // Reads always begin at the status register
                  r_nxt.rd_ptr = 2'h0;
                  r_nxt.tx     = first_tx;
                  r_nxt.drive  = ~first_tx[7];                       // R23
                  r_nxt.state  = lnbc_pkg::ST_READ;
               end
               else
               begin
                  // Ack ends at this fall; the data byte follows
                  r_nxt.drive = 1'b0;
                  r_nxt.state = lnbc_pkg::ST_WRITE;
               end
            end
         end
         lnbc_pkg::ST_WRITE:
         begin
            if (scl_rise && r.cnt != lnbc_pkg::CNT_BYTE_DONE)
            begin
               r_nxt.shreg = {r.shreg[6:0], r.sda_s};               // R5
               r_nxt.cnt   = 4'(r.cnt + 4'h1);
            end
            else if (scl_fall && r.cnt == lnbc_pkg::CNT_BYTE_DONE)
            begin
               r_nxt.drive = 1'b1;                                  // R9 R26
               r_nxt.state = lnbc_pkg::ST_WRITE_ACK;
               case (r.shreg[lnbc_pkg::SEL_MSB:lnbc_pkg::SEL_LSB])  // R10 R11
                  lnbc_pkg::SEL_TONE:
                  begin
                     r_nxt.tone.tone_enable =
                        r.shreg[lnbc_pkg::TONE_EN_BIT];              // R18
                     r_nxt.tone.modulation_select =
                        r.shreg[lnbc_pkg::MOD_SEL_BIT];              // R18
                     r_nxt.tone.tone_threshold_sel =
                        r.shreg[lnbc_pkg::TONE_THR_BIT];             // R19
                  end
                  lnbc_pkg::SEL_COMMAND:
                  begin
                     r_nxt.cmd.current_mode_sel =
                        r.shreg[lnbc_pkg::CUR_MODE_BIT];             // R21
                     r_nxt.cmd.voltage_pin_enable =
                        r.shreg[lnbc_pkg::VPIN_EN_BIT];              // R22
                     r_nxt.cmd.ilimit_sel_high =
                        r.shreg[lnbc_pkg::ILIM_HI_BIT];              // R20
                     r_nxt.cmd.ilimit_sel_low =
                        r.shreg[lnbc_pkg::ILIM_LO_BIT];              // R20
                  end
                  lnbc_pkg::SEL_CONTROL:
                  begin
                     r_nxt.ctrl.output_enable =
                        r.shreg[lnbc_pkg::OUT_EN_BIT];               // R27
                     r_nxt.ctrl.high_range_sel =
                        r.shreg[lnbc_pkg::HI_RANGE_BIT];             // R27
                     r_nxt.ctrl.low_range_sel =
                        r.shreg[lnbc_pkg::LO_RANGE_BIT];             // R27
                  end
                  default:
                  begin
                     // Status and undefined codes leave every register as is
                     r_nxt.cmd = r.cmd;                              // R26
                  end
               endcase
            end
         end
         lnbc_pkg::ST_WRITE_ACK:
         begin
            if (scl_fall)
            begin
               // Further bytes in the same transfer are taken as more writes
               r_nxt.drive = 1'b0;
               r_nxt.cnt   = 4'h0;
               r_nxt.state = lnbc_pkg::ST_WRITE;
            end
         end
         lnbc_pkg::ST_READ:
         begin
            if (scl_rise)
            begin
               r_nxt.cnt = 4'(r.cnt + 4'h1);
            end
            else if (scl_fall)
            begin
               if (r.cnt == lnbc_pkg::CNT_BYTE_DONE)
               begin
                  // Release the line so the master can answer
                  r_nxt.drive = 1'b0;                               // R6
                  r_nxt.state = lnbc_pkg::ST_READ_ACK;
               end
               else
               begin
                  r_nxt.drive = ~r.tx[bit_idx];                     // R1 R23
               end
            end
         end
         lnbc_pkg::ST_READ_ACK:
         begin
            if (scl_rise)
            begin
               // Master answer is taken at the rise and acted on at the fall
               r_nxt.more = ~r.sda_s;                               // R23
            end
            else if (scl_fall)
            begin
               if (r.more)
               begin
                  r_nxt.rd_ptr = 2'(r.rd_ptr + 2'h1);
                  r_nxt.tx     = next_tx;
                  r_nxt.drive  = ~next_tx[7];
                  r_nxt.cnt    = 4'h0;
                  r_nxt.state  = lnbc_pkg::ST_READ;
               end
               else
               begin
                  r_nxt.state = lnbc_pkg::ST_IGNORE;
               end
            end
         end
         lnbc_pkg::ST_IGNORE:
         begin
            r_nxt.drive = 1'b0;
         end
         default:
         begin
            r_nxt.drive = 1'b0;
            r_nxt.state = lnbc_pkg::ST_IDLE;
         end
      endcase

      // A start restarts address reception from any state
      if (bus_start)
      begin
         r_nxt.drive = 1'b0;
         r_nxt.cnt   = 4'h0;
         r_nxt.state = lnbc_pkg::ST_ADDR;                           // R2 R4
      end
      else if (bus_stop)
      begin
         r_nxt.drive = 1'b0;
         r_nxt.state = lnbc_pkg::ST_IDLE;                           // R3
      end

      // Lockout dominates everything; registers stay cleared until power is good
      if (!r.pg_s)
      begin
         r_nxt.drive = 1'b0;                                        // R7 R24
         r_nxt.state = lnbc_pkg::ST_IDLE;
         r_nxt.tone  = '0;
         r_nxt.cmd   = '0;
         r_nxt.ctrl  = '0;                                          // R24
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         r <= '0;                                                   // R12
         // Bus flops start at the idle high level, so release shows no false edge
         r.scl_m <= 1'b1;
         r.scl_s <= 1'b1;
         r.scl_d <= 1'b1;
         r.sda_m <= 1'b1;
         r.sda_s <= 1'b1;
         r.sda_d <= 1'b1;
      end
      else
      begin
         r <= r_nxt;
      end
   end

   // Open drain: only ever pulls low, enable active low
   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~r.drive;
   assign o_tone     = r.tone;
   assign o_cmd      = r.cmd;
   assign o_ctrl     = r.ctrl;

endmodule // lnbc_i2c_regs

`default_nettype wire

//--- testbench/lnbc_i2c_regs_asserts.sv
// Checker for the LNB controller two-wire register slave
`timescale 1ns/100ps
`default_nettype none
module lnbc_i2c_regs_asserts
(
   input wire logic                 i_clock,
   input wire logic                 i_resetn,
   input wire logic                 i_scl,
   input wire logic                 i_sda,
   input wire logic                 o_sda,
   input wire logic                 o_sda_oe_n,
   input wire logic                 i_power_good,
   input wire lnbc_pkg::lnbc_tone_t o_tone,
   input wire lnbc_pkg::lnbc_cmd_t  o_cmd,
   input wire lnbc_pkg::lnbc_ctrl_t o_ctrl
);
   logic       scl_r;
   logic       sda_r;
   logic [3:0] rise_r;
   // Rises since start; saturates so long reads never wrap
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         scl_r  <= 1'b1;
         sda_r  <= 1'b1;
         rise_r <= 4'h0;
      end
      else
      begin
         scl_r <= i_scl;
         sda_r <= i_sda;
         if (scl_r && i_scl && sda_r && !i_sda)
            rise_r <= 4'h0;
         else if (!scl_r && i_scl && rise_r != 4'hf)
            rise_r <= rise_r + 4'h1;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   sequence s_lockout;
      (!i_power_good) [*6];
   endsequence
   sequence s_zero;
      o_tone == 3'h0 && o_cmd == 4'h0 && o_ctrl == 3'h0 && o_sda_oe_n;
   endsequence
   a_reset_clear: assert property ($rose(i_resetn) |-> s_zero)
      else $error("outputs not clear after reset");
   a_sda_value_low: assert property (o_sda == 1'b0)
      else $error("data pin value not low");
   a_lockout_quiet: assert property (s_lockout |-> o_sda_oe_n)
      else $error("drive while power is not good");
   a_lockout_clear: assert property (s_lockout |-> s_zero)
      else $error("registers kept while power is not good");
   a_drive_low_scl: assert property ($fell(o_sda_oe_n) |-> !i_scl)
      else $error("drive began with clock high");
   a_drive_holds_high: assert property (!o_sda_oe_n && $rose(i_scl) |-> !o_sda_oe_n [*8])
      else $error("drive dropped during clock high");
   a_byte_before_ack: assert property ($fell(o_sda_oe_n) |-> rise_r >= 4'h8)
      else $error("drive before a whole byte");
   a_regs_on_low: assert property ($changed({o_tone, o_cmd, o_ctrl}) && i_power_good
      && $past(i_power_good, 4) |-> !i_scl)
      else $error("register changed with clock high");
endmodule // lnbc_i2c_regs_asserts
bind lnbc_i2c_regs lnbc_i2c_regs_asserts i_lnbc_i2c_regs_asserts
(
   .i_clock(i_clock), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n), .i_power_good(i_power_good), .o_tone(o_tone), .o_cmd(o_cmd),
   .o_ctrl(o_ctrl)
);
`default_nettype wire

//--- testbench/lnbc_host.sv
// Bus master model standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module lnbc_host
(
   input  wire logic i_clock,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   localparam int Q = 10;
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic half();
      repeat (Q) @(posedge i_clock);
      #1;
   endtask
   // Preceded by a stop, or by the idle bus after reset; never a repeated start
   task automatic start();
      o_sda = 1'b0;
      half();
      o_scl = 1'b0;
      half();
   endtask
   task automatic stop();
      o_sda = 1'b0;
      half();
      o_scl = 1'b1;
      half();
      o_sda = 1'b1;
      half();
   endtask
   // Nine bits MSB first; a 1 releases the line so the far side can answer
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int k = 8; k >= 0; k--)
      begin
         o_sda = tx[k];
         half();
         o_scl = 1'b1;
         half();
         rx[k] = i_sda;
         o_scl = 1'b0;
         half();
      end
   endtask
endmodule // lnbc_host
`default_nettype wire

//--- testbench/tb_lnbc_i2c_regs.sv
// Self-checking bench for the LNB controller two-wire register slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_lnbc_i2c_regs;
   logic                   clock, resetn, pg, sel_hi, sel_lo, scl, host_sda, o_sda, oe_n;
   lnbc_pkg::lnbc_status_t status;
   lnbc_pkg::lnbc_tone_t   tone, et;
   lnbc_pkg::lnbc_cmd_t    cmd, ec;
   lnbc_pkg::lnbc_ctrl_t   ctrl, ectl;
   logic [7:0]             rnd;
   logic [8:0]             rx;
   int                     n_mismatch, tests_run;
   // Wired-AND with the pull-up: a released line reads high
   wire logic              sda_w = host_sda & (oe_n | o_sda);
   lnbc_i2c_regs i_lnbc_i2c_regs
   (
      .i_clock(clock), .i_resetn(resetn), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
      .o_sda_oe_n(oe_n), .i_addr_sel_hi(sel_hi), .i_addr_sel_lo(sel_lo),
      .i_power_good(pg), .i_status(status), .o_tone(tone), .o_cmd(cmd), .o_ctrl(ctrl)
   );
   lnbc_host i_lnbc_host (.i_clock(clock), .i_sda(sda_w), .o_scl(scl), .o_sda(host_sda));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] exp_byte(input int i);
      case (i % 4)
         0: return {3'h0, status};
         1: return {3'h1, et, 2'h0};
         2: return {3'h2, ec[3:2], 1'b0, ec[1:0]};
         default: return {3'h3, ectl[2], 2'h0, ectl[1:0]};
      endcase
   endfunction
   task automatic check_regs();
      `CHK(tone, et)
      `CHK(cmd, ec)
      `CHK(ctrl, ectl)
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic nack);
      i_lnbc_host.start();
      i_lnbc_host.xfer({5'h02, a, 2'h1}, rx);
      `CHK(rx[0], nack)
      if (!nack)
      begin
         i_lnbc_host.xfer({d, 1'b1}, rx);
         `CHK(rx[0], 1'b0)
         case (d[7:5])
            3'h1: et = d[4:2];
            3'h2: ec = {d[4:3], d[1:0]};
            3'h3: ectl = {d[4], d[1:0]};
            default: ;
         endcase
      end
      i_lnbc_host.stop();
      check_regs();
   endtask
   task automatic rd(input int n);
      i_lnbc_host.start();
      i_lnbc_host.xfer({5'h02, sel_hi, sel_lo, 2'h3}, rx);
      `CHK(rx[0], 1'b0)
      for (int i = 0; i < n; i++)
      begin
         i_lnbc_host.xfer({8'hff, i == n - 1}, rx);
         `CHK(rx[8:1], exp_byte(i))
      end
      i_lnbc_host.stop();
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Whole run needs about 26000 clocks
   initial
   begin
      #800000;
      n_mismatch++;
      finish_test();
   end
   initial
   begin
      {resetn, pg, sel_hi, sel_lo, status, rnd} = {4'h4, 5'h00, 8'h61};
      {et, ec, ectl, n_mismatch, tests_run} = '0;
      repeat (2) @(posedge clock);
      #1 resetn = 1'b1;
      check_regs();
      repeat (6) @(posedge clock);
      #1;
      // Every select code, each at one pin address, plus a neighbour address
      for (int s = 0; s < 8; s++)
      begin
         {sel_hi, sel_lo} = s[1:0];
         rnd = lfsr(rnd);
         wr(s[1:0], {s[2:0], rnd[4:0]}, 1'b0);
         wr(s[1:0] ^ 2'h1, 8'h7f, 1'b1);
      end
      for (int k = 0; k < 20; k++)
      begin
         rnd = lfsr(rnd);
         wr({sel_hi, sel_lo}, rnd, 1'b0);
      end
      for (int k = 0; k < 3; k++)
      begin
         rnd = lfsr(rnd);
         status = rnd[4:0];
         rd(5);
      end
      wr({sel_hi, sel_lo}, 8'h7f, 1'b0);
      pg = 1'b0;
      repeat (8) @(posedge clock);
      #1 {et, ec, ectl} = '0;
      `CHK(ctrl, 3'h0)
      wr({sel_hi, sel_lo}, 8'h7f, 1'b1);
      pg = 1'b1;
      repeat (8) @(posedge clock);
      #1 wr({sel_hi, sel_lo}, 8'h5f, 1'b0);
      resetn = 1'b0;
      repeat (2) @(posedge clock);
      #1 resetn = 1'b1;
      {et, ec, ectl} = '0;
      check_regs();
      finish_test();
   end
endmodule // tb_lnbc_i2c_regs
`default_nettype wire
